// *** core/hbsc_top.sv ***
// serial command/status core of the ten-channel half-bridge driver
`timescale 1ns/100ps
`default_nettype none
`include "hbsc_defs.svh"

module hbsc_top (
    input  wire logic                CLK_I,
    input  wire logic                RESETN_I,
    input  wire logic                SCLK_I,
    input  wire logic                CHIP_SELECT_N_I,
    input  wire logic                SER_DATA_I,
    output logic                     SER_DATA_O,
    output logic                     SER_DATA_OE_O,
    input  wire logic                ENABLE_I,
    input  wire logic                PULSE_INPUT_ONE_I,
    input  wire logic                PULSE_INPUT_TWO_I,
    input  wire logic                THERMAL_SHUTDOWN_I,
    input  wire logic                THERMAL_WARNING_I,
    input  wire logic                SUPPLY_UNDER_I,
    input  wire logic                SUPPLY_OVER_I,
    input  wire logic [9:0]          OVERCURRENT_I,
    input  wire logic [9:0]          UNDERLOAD_I,
    output logic [9:0]               HIGH_SIDE_ON_O,
    output logic [9:0]               LOW_SIDE_ON_O,
    output logic                     AWAKE_O,
    output var hbsc_pkg::hbsc_word_t COMMAND_WORD_O,
    output var hbsc_pkg::hbsc_word_t STATUS_WORD_O
);
    import hbsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [27:0] sync_meta;
    logic [27:0] sync_q;
    logic        cs_d;
    logic        tog_meta;
    logic        tog_q;
    logic        tog_seen;
    logic        frame_end;

    // carrier to the serial side, declared before the synchroniser reads it
    hbsc_link_if lnk ();

    wire [27:0] raw_pins = {CHIP_SELECT_N_I, ENABLE_I, PULSE_INPUT_TWO_I, PULSE_INPUT_ONE_I,
                            THERMAL_SHUTDOWN_I, THERMAL_WARNING_I, SUPPLY_UNDER_I,
                            SUPPLY_OVER_I, OVERCURRENT_I, UNDERLOAD_I};

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            sync_meta <= `HBSC_SYNC_RESET;
            sync_q    <= `HBSC_SYNC_RESET;
            cs_d      <= 1'b1;
            tog_meta  <= 1'b0;
            tog_q     <= 1'b0;
            tog_seen  <= 1'b0;
        end
        else
        begin
            sync_meta <= raw_pins;
            sync_q    <= sync_meta;
            cs_d      <= sync_q[27];
            tog_meta  <= lnk.frame_tog;
            tog_q     <= tog_meta;
            tog_seen  <= frame_end ? tog_q : tog_seen;
        end
    end

    wire       cs_s   = sync_q[27];
    wire       en_s   = sync_q[26];
    wire [1:0] pwm_s  = sync_q[25:24];
    wire       tsd_s  = sync_q[23];
    wire       tw_s   = sync_q[22];
    wire       uv_s   = sync_q[21];
    wire       ov_s   = sync_q[20];
    wire [9:0] oc_s   = sync_q[19:10];
    wire [9:0] ul_s   = sync_q[9:0];

    ////////////////////////////////////////////////////////////////////////
    // frame end and validity
    // the shifter owns everything clocked by the serial clock

    hbsc_shift u_shift (
        .sclk_i   (SCLK_I),
        .resetn_i (RESETN_I),
        .cs_n_i   (CHIP_SELECT_N_I),
        .sdi_i    (SER_DATA_I),
        .sdo_o    (SER_DATA_O),
        .sdo_oe_o (SER_DATA_OE_O),
        .lnk      (lnk.link)
    );

    // word and count are quiet once chip select is high, so read directly
    assign frame_end       = cs_s & ~cs_d;
    wire        clocked    = tog_q != tog_seen;
    wire        len_ok     = lnk.bit_cnt >= 6'(`HBSC_WORD_W)
                             && lnk.bit_cnt[2:0] == 3'h0;
    wire        frame_ok   = frame_end & clocked & len_ok & en_s;
    hbsc_word_t rx_w;
    assign rx_w = lnk.rx_word;
    wire        cmd_sel    = rx_w[`HBSC_CMD_SEL];
    wire        srr_go     = frame_ok & rx_w[`HBSC_CMD_SRR];
    wire [9:0]  cmd_grp    = cmd_sel ? `HBSC_UPPER_MASK : `HBSC_LOWER_MASK;
    wire [9:0]  clr_mask   = srr_go ? cmd_grp : 10'h000;

    ////////////////////////////////////////////////////////////////////////
    // command state
    hbsc_word_t cmd_word;
    logic       sel;
    logic       uldsc;
    logic       ovlo;
    logic       tsd_l;
    logic [9:0] ch_en;
    logic [9:0] ch_cnf;
    logic [9:0] oc_l;
    logic [9:0] ul_l;
    logic [9:0] hs;
    logic [9:0] ls;
    logic [9:0] want_on;
    logic [9:0] want_hs;
    logic [9:0] next_en;
    logic [9:0] next_cnf;
    hbsc_chst_t fld [10];

    wire        lockout  = uv_s | (ov_s & ovlo);
    wire        supply_fault_flag      = uv_s | ov_s;
    wire [9:0]  active   = hs | ls;
    wire [9:0]  oc_set   = oc_s & active;
    wire [9:0]  ul_set   = ul_s & active & {10{uldsc}};
    wire [9:0]  next_oc  = (oc_l & ~clr_mask) | oc_set;
    wire [9:0]  next_ul  = (ul_l & ~clr_mask) | ul_set;
    wire        next_tsd = (tsd_l & ~srr_go) | tsd_s;

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            cmd_word <= `HBSC_CMD_RESET;
            sel      <= 1'b0;
            uldsc    <= 1'b0;
            ovlo     <= 1'b0;
            ch_en    <= '0;
            ch_cnf   <= '0;
            oc_l     <= '0;
            ul_l     <= '0;
            tsd_l    <= 1'b0;
        end
        else
        begin
            cmd_word <= frame_ok ? rx_w : cmd_word;
            sel      <= frame_ok ? cmd_sel : sel;
            uldsc    <= frame_ok ? rx_w[`HBSC_CMD_ULDSC] : uldsc;
            ovlo     <= frame_ok ? rx_w[`HBSC_CMD_OVLO] : ovlo;
            ch_en    <= next_en;
            ch_cnf   <= next_cnf;
            oc_l     <= next_oc;
            ul_l     <= next_ul;
            tsd_l    <= next_tsd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel field load, drive and dead time
    genvar i;
    generate
        for (i = 0; i < `HBSC_CHAN_N; i++)
        begin : g_chan
            localparam bit UPPER = (i >= `HBSC_LOW_N);
            localparam int J     = UPPER ? i - `HBSC_LOW_N : i;
            logic [8:0] gap;
            logic [9:0] ls_low_run;
            logic       hs_q;
            logic       ls_q;

            // enable at bit 2j+2, high-side select at bit 2j+1 of the word
            wire load = frame_ok & (cmd_sel == UPPER);
            assign next_en[i]  = load ? rx_w[2 * J + 2] : ch_en[i];
            assign next_cnf[i] = load ? rx_w[2 * J + 1] : ch_cnf[i];

            // two channels give forward, reverse, brake (both same) or off
            assign want_on[i] = en_s & ch_en[i] & ~oc_l[i] & ~ul_l[i]
                                & ~tsd_l & ~lockout;
            if (i < 2)
            begin : g_pwm
                assign want_hs[i] = want_on[i] & (ch_cnf[i] | pwm_s[i]);
            end
            else
            begin : g_cfg
                assign want_hs[i] = want_on[i] & ch_cnf[i];
            end

            wire next_hs = want_hs[i] & ~ls[i] & (gap == `HBSC_DEAD_CYC);
            wire next_ls = want_on[i] & ~want_hs[i] & ~hs[i];

            always_ff @(posedge CLK_I or negedge RESETN_I)
            begin
                if (!RESETN_I)
                begin
                    hs_q       <= 1'b0;
                    ls_q       <= 1'b0;
                    gap        <= '0;
                    ls_low_run <= '0;
                end
                else
                begin
                    hs_q       <= next_hs;
                    ls_q       <= next_ls;
                    gap        <= ls[i] ? '0 : (gap == `HBSC_DEAD_CYC) ? gap : gap + 9'h001;
                    ls_low_run <= ls[i] ? '0 : (&ls_low_run) ? ls_low_run : ls_low_run + 10'h001;
                end
            end

            // one driver per bit of the shared gate vectors
            assign hs[i] = hs_q;
            assign ls[i] = ls_q;

            assign fld[i] = oc_l[i]   ? HBSC_ST_OVERCURRENT :
                            ul_l[i]   ? HBSC_ST_UNDERLOAD :
                            active[i] ? HBSC_ST_ENABLED : HBSC_ST_DISABLED;

            dead_time_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
                $rose(hs[i]) |-> ls_low_run >= 10'd500 && !ls[i])
                else $error("high side on too soon after low side off");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // status word, held still while chip select is low
    hbsc_word_t stat;
    hbsc_word_t next_stat;
    logic       stat_tsd;
    wire  [9:0] sel_mask = sel ? `HBSC_UPPER_MASK : `HBSC_LOWER_MASK;

    genvar j;
    generate
        for (j = 0; j < `HBSC_LOW_N; j++)
        begin : g_stat
            if (j < `HBSC_UPPER_N)
            begin : g_both
                assign next_stat[2 * j + 2 : 2 * j + 1] =
                    sel ? fld[j + `HBSC_LOW_N] : fld[j];
            end
            else
            begin : g_low
                assign next_stat[2 * j + 2 : 2 * j + 1] = sel ? 2'h0 : fld[j];
            end
        end
    endgenerate

    assign next_stat[`HBSC_ST_OCS] = |(oc_l & sel_mask);
    assign next_stat[`HBSC_ST_PSF] = supply_fault_flag;
    assign next_stat[`HBSC_ST_ULD] = |(ul_l & sel_mask);
    assign next_stat[`HBSC_ST_TW]  = tw_s;

    // refresh only between frames so the serial side reads a still word
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            stat     <= `HBSC_STAT_RESET;
            stat_tsd <= 1'b0;
        end
        else
        begin
            stat     <= (cs_s & cs_d) ? next_stat : stat;
            stat_tsd <= (cs_s & cs_d) ? tsd_l : stat_tsd;
        end
    end

    assign lnk.status     = stat;
    assign lnk.tsd        = stat_tsd;
    assign HIGH_SIDE_ON_O = hs;
    assign LOW_SIDE_ON_O  = ls;
    assign AWAKE_O        = en_s;
    assign COMMAND_WORD_O = cmd_word;
    assign STATUS_WORD_O  = stat;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    sequence s_good_frame;
        frame_ok;
    endsequence

    sequence s_frame_open;
        !cs_s ##1 !cs_s;
    endsequence

    cmd_apply_a: assert property (s_good_frame |=> cmd_word == $past(rx_w))
        else $error("valid frame not applied");

    bad_len_a: assert property (frame_end && !len_ok |=> $stable(cmd_word))
        else $error("bad length frame changed command");

    stat_freeze_a: assert property (s_frame_open |-> $stable(stat))
        else $error("status changed during frame");

    sleep_off_a: assert property (!en_s |=> hs == 10'h000 && ls == 10'h000)
        else $error("driver on while asleep");

    psf_bit_a: assert property (cs_s && cs_d && supply_fault_flag |=> stat[14])
        else $error("supply fault not reported");

    srr_tsd_a: assert property (s_good_frame ##0 rx_w[15] && !tsd_s |=> !tsd_l)
        else $error("status reset did not clear thermal latch");

    srr_ul_a: assert property (srr_go && !cmd_sel && !(|ul_set) |=> ul_l[5:0] == 6'h00)
        else $error("status reset did not clear underload");

    group_sel_a: assert property (s_good_frame |=> sel == $past(cmd_sel))
        else $error("group select not taken from command");

    pwm_drive_a: assert property (want_on[0] && pwm_s[0] && ls[0]
        |=> !ls[0] ##[1:502] (hs[0] || !(want_on[0] && pwm_s[0])))
        else $error("pulse input did not drive output one high");

endmodule

`default_nettype wire

// *** core/hbsc_defs.svh ***
// constants of the half-bridge serial command/status block
`ifndef HBSC_DEFS_SVH
`define HBSC_DEFS_SVH

`define HBSC_WORD_W      16
`define HBSC_BYTE_W      8
`define HBSC_CNT_W       6
`define HBSC_CNT_MAX     6'h3f
`define HBSC_CHAN_N      10
`define HBSC_LOW_N       6
`define HBSC_UPPER_N     4

`define HBSC_CMD_SRR     15
`define HBSC_CMD_SEL     14
`define HBSC_CMD_ULDSC   13
`define HBSC_CMD_OVLO    0

`define HBSC_ST_OCS      15
`define HBSC_ST_PSF      14
`define HBSC_ST_ULD      13
`define HBSC_ST_TW       0

`define HBSC_CMD_RESET   16'h0000
`define HBSC_STAT_RESET  16'h0000
`define HBSC_UPPER_MASK  10'h3c0
`define HBSC_LOWER_MASK  10'h03f
`define HBSC_SYNC_RESET  28'h8000000

`define HBSC_CLK_NS      10
`define HBSC_DEAD_NS     5000
`define HBSC_GAP_W       9
`define HBSC_DEAD_CYC    9'((`HBSC_DEAD_NS + `HBSC_CLK_NS - 1) / `HBSC_CLK_NS)

`endif

// *** core/hbsc_pkg.sv ***
// types shared by the half-bridge serial command/status block
package hbsc_pkg;

    typedef logic [15:0] hbsc_word_t;

    // declaration order gives 00 off, 01 overcurrent, 10 underload, 11 on
    typedef enum logic [1:0] {
        HBSC_ST_DISABLED,
        HBSC_ST_OVERCURRENT,
        HBSC_ST_UNDERLOAD,
        HBSC_ST_ENABLED
    } hbsc_chst_t;

endpackage

// *** core/hbsc_link_if.sv ***
// carrier between the core domain and the serial clock domain
`timescale 1ns/100ps
`default_nettype none

interface hbsc_link_if;
    import hbsc_pkg::*;

    hbsc_word_t  status;
    logic        tsd;
    hbsc_word_t  rx_word;
    logic [5:0]  bit_cnt;
    logic        frame_tog;

    modport core (output status, output tsd, input rx_word, input bit_cnt, input frame_tog);
    modport link (input status, input tsd, output rx_word, output bit_cnt, output frame_tog);
endinterface

`default_nettype wire

// *** core/hbsc_shift.sv ***
// serial shifter running on the serial clock
`timescale 1ns/100ps
`default_nettype none
`include "hbsc_defs.svh"

module hbsc_shift (
    input  wire logic   sclk_i,
    input  wire logic   resetn_i,
    input  wire logic   cs_n_i,
    input  wire logic   sdi_i,
    output logic        sdo_o,
    output logic        sdo_oe_o,
    hbsc_link_if.link   lnk
);
    import hbsc_pkg::*;

    wire        frame_rst_n = resetn_i & ~cs_n_i;
    logic       fall_seen;
    logic       rise_seen;
    hbsc_word_t chain;
    hbsc_word_t rx;
    logic [5:0] cnt;
    logic       tog;

    ////////////////////////////////////////////////////////////////////////
    // input side: falling edges; word and count survive the frame end
    always_ff @(negedge sclk_i or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            fall_seen <= 1'b0;
        else
            fall_seen <= 1'b1;
    end

    always_ff @(negedge sclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rx  <= `HBSC_CMD_RESET;
            cnt <= '0;
            tog <= 1'b0;
        end
        else
        begin
            rx  <= {rx[14:0], sdi_i};
            cnt <= !fall_seen ? 6'h01 : (cnt == `HBSC_CNT_MAX) ? cnt : cnt + 6'h01;
            tog <= fall_seen ? tog : ~tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output side: first rising edge loads status, later ones pass data on
    always_ff @(posedge sclk_i or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            rise_seen <= 1'b0;
            chain     <= `HBSC_STAT_RESET;
        end
        else
        begin
            rise_seen <= 1'b1;
            chain     <= !rise_seen ? lnk.status : {chain[14:0], rx[0]};
        end
    end

    assign sdo_o         = rise_seen ? chain[15] : lnk.tsd;
    assign sdo_oe_o      = ~cs_n_i;
    assign lnk.rx_word   = rx;
    assign lnk.bit_cnt   = cnt;
    assign lnk.frame_tog = tog;

    ////////////////////////////////////////////////////////////////////////
    bit_count_a: assert property (@(negedge sclk_i) disable iff (!frame_rst_n)
        fall_seen && $past(fall_seen) && $past(cnt) != 6'h3f |-> cnt == $past(cnt) + 6'h01)
        else $error("bit count did not advance by one");

endmodule

`default_nettype wire

// *** verif/hbsc_master_model.sv ***
// serial bus master model for the command/status link
`timescale 1ns/100ps
`default_nettype none

module hbsc_master_model (
    output logic       sclk_o,
    output logic       cs_n_o,
    output logic       sdi_o,
    input  wire logic  sdo_i,
    input  wire logic  sdo_oe_i
);
    logic [31:0] rx;
    logic        pre;
    logic        oe_ok;
    event        done;

    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
    end

    // link clock runs only inside a frame, 15 ns period, msb first
    task automatic frame(input int n, input logic [31:0] data);
        #3.3;
        rx     = 32'h0;
        oe_ok  = 1'b1;
        cs_n_o = 1'b0;
        // give chip select time to freeze the core's status word before it is loaded
        #40;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi_o = data[i];
            #6.5;
            if (i == n - 1)
                pre = sdo_i;
            oe_ok  = oe_ok & (sdo_oe_i === 1'b1);
            sclk_o = 1'b1;
            #7.5;
            sclk_o = 1'b0;
            rx     = {rx[30:0], sdo_i};
            #1;
        end
        #6.5;
        cs_n_o = 1'b1;
        // data pin is pulled down once released
        sdi_o  = 1'b0;
        #1;
        oe_ok  = oe_ok & (sdo_oe_i === 1'b0);
        -> done;
    endtask
endmodule

`default_nettype wire

// *** verif/hbsc_tb_top.sv ***
// self-checking testbench of the serial command/status core
`timescale 1ns/100ps
`default_nettype none

module hbsc_tb_top;
    import hbsc_pkg::*;

    typedef struct {
        logic [31:0] exp;
        logic [31:0] mask;
        logic        pre;
        hbsc_word_t  st;
        hbsc_word_t  sm;
    } hbsc_note_t;

    logic        clk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, en, pw1, pw2;
    logic        tsd, tw, suv, sov, awake;
    logic [9:0]  oc, ul, hs, ls;
    hbsc_word_t  cmd_word;
    hbsc_word_t  stw;
    hbsc_word_t  last_cmd;
    logic [31:0] r;
    hbsc_note_t  fq[$];
    hbsc_note_t  fe;
    hbsc_word_t  cq[$];
    logic [20:0] gq[$];
    event        gate_ev;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    hbsc_top dut (.CLK_I(clk), .RESETN_I(rst_n), .SCLK_I(sclk), .CHIP_SELECT_N_I(cs_n),
        .SER_DATA_I(sdi), .SER_DATA_O(sdo), .SER_DATA_OE_O(sdo_oe), .ENABLE_I(en),
        .PULSE_INPUT_ONE_I(pw1), .PULSE_INPUT_TWO_I(pw2), .THERMAL_SHUTDOWN_I(tsd),
        .THERMAL_WARNING_I(tw), .SUPPLY_UNDER_I(suv), .SUPPLY_OVER_I(sov),
        .OVERCURRENT_I(oc), .UNDERLOAD_I(ul), .HIGH_SIDE_ON_O(hs), .LOW_SIDE_ON_O(ls),
        .AWAKE_O(awake), .COMMAND_WORD_O(cmd_word), .STATUS_WORD_O(stw));

    hbsc_master_model m (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo),
        .sdo_oe_i(sdo_oe));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic fail(input string msg);
        n_mismatch++;
        $display("[ERR] %0t %s", $time, msg);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // note the expected frame and command, then run it; ok = frame is accepted
    task automatic send(input int n, input logic [31:0] data, input hbsc_word_t st,
                        input hbsc_word_t sm, input logic pre, input logic ok);
        hbsc_note_t  e;
        logic [47:0] full;
        full   = {st, 32'(data << (32 - n))};
        e.exp  = 32'(full >> (48 - n));
        e.mask = 32'({sm, 32'hffffffff} >> (48 - n));
        e.pre  = pre;
        e.st   = st;
        e.sm   = sm;
        fq.push_back(e);
        if (ok && data[15:0] !== last_cmd)
        begin
            cq.push_back(data[15:0]);
            last_cmd = data[15:0];
        end
        m.frame(n, data);
        repeat (10) @(negedge clk);
    endtask

    // expected {awake, high sides, low sides}
    task automatic gate(input logic [20:0] exp);
        gq.push_back(exp);
        -> gate_ev;
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(m.done)
    begin
        cmp_count++;
        if (fq.size() == 0)
            fail("frame without note");
        else
        begin
            fe = fq.pop_front();
            if (((m.rx ^ fe.exp) & fe.mask) !== 32'h0 || m.pre !== fe.pre
                || !m.oe_ok)
                fail($sformatf("frame %h pre %b want %h pre %b", m.rx, m.pre, fe.exp, fe.pre));
            // still frozen here: chip select has not yet crossed into the core
            cmp_count++;
            if (((stw ^ fe.st) & fe.sm) !== 16'h0)
                fail($sformatf("status word %h want %h", stw, fe.st));
        end
    end

    always @(gate_ev)
    begin
        cmp_count++;
        if ({awake, hs, ls} !== gq[0])
            fail($sformatf("gates %h want %h", {awake, hs, ls}, gq[0]));
        gq.pop_front();
    end

    initial
    begin
        @(posedge rst_n);
        forever
        begin
            @(cmd_word);
            cmp_count++;
            if (cq.size() == 0)
                fail("command changed without note");
            else if (cmd_word !== cq.pop_front())
                fail($sformatf("command word %h", cmd_word));
        end
    end

    // whole sequence takes about 2000 cycles
    initial
    begin
        #300000;
        fail("timeout");
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, en, pw1, pw2, tsd, tw, suv, sov} = 8'h0;
        oc = 10'h0;
        ul = 10'h0;
        last_cmd = 16'h0;
        void'($urandom(36));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        gate(21'h0);
        send(16, 32'h1554, 16'h0, 16'hffff, 1'b0, 1'b0);
        en = 1'b1;
        repeat (10) @(negedge clk);
        send(16, 32'h1554, 16'h0, 16'hffff, 1'b0, 1'b1);
        gate({1'b1, 10'h0, 10'h03f});
        send(16, 32'h4154, 16'h1ffe, 16'hffff, 1'b0, 1'b1);
        gate({1'b1, 10'h0, 10'h3ff});
        r = $urandom;
        send(12, r, 16'h01fe, 16'hffff, 1'b0, 1'b0);
        send(20, r, 16'h01fe, 16'hffff, 1'b0, 1'b0);
        {pw1, pw2} = 2'b11;
        repeat (600) @(negedge clk);
        gate({1'b1, 10'h003, 10'h3fc});
        {pw1, pw2} = 2'b00;
        repeat (20) @(negedge clk);
        gate({1'b1, 10'h0, 10'h3ff});
        {sov, tw} = 2'b11;
        repeat (10) @(negedge clk);
        send(16, 32'h1556, 16'h41ff, 16'hffff, 1'b0, 1'b1);
        repeat (390) @(negedge clk);
        gate({1'b1, 10'h0, 10'h3fe});
        repeat (120) @(negedge clk);
        gate({1'b1, 10'h001, 10'h3fe});
        {sov, tw} = 2'b00;
        repeat (10) @(negedge clk);
        r = $urandom;
        send(32, {r[15:0], 16'h4154}, 16'h1ffe, 16'hffff, 1'b0, 1'b1);
        oc = 10'h004;
        repeat (10) @(negedge clk);
        send(16, 32'h1556, 16'h01fe, 16'hffff, 1'b0, 1'b1);
        gate({1'b1, 10'h001, 10'h3fa});
        oc = 10'h0;
        repeat (10) @(negedge clk);
        send(16, 32'h9556, 16'h9fbe, 16'hffff, 1'b0, 1'b1);
        send(16, 32'h3556, 16'h1ffe, 16'hffff, 1'b0, 1'b1);
        ul = 10'h008;
        repeat (10) @(negedge clk);
        send(16, 32'h3556, 16'h3f7e, 16'hffff, 1'b0, 1'b1);
        ul = 10'h0;
        repeat (10) @(negedge clk);
        send(16, 32'hb556, 16'h3f7e, 16'hffff, 1'b0, 1'b1);
        send(16, 32'h1556, 16'h1ffe, 16'hffff, 1'b0, 1'b1);
        suv = 1'b1;
        repeat (10) @(negedge clk);
        gate({1'b1, 20'h0});
        suv = 1'b0;
        tsd = 1'b1;
        repeat (10) @(negedge clk);
        send(16, 32'h1556, 16'h0, 16'h4001, 1'b1, 1'b1);
        tsd = 1'b0;
        repeat (10) @(negedge clk);
        send(16, 32'h9556, 16'h0, 16'h4001, 1'b1, 1'b1);
        send(16, 32'h1556, 16'h0, 16'h4001, 1'b0, 1'b1);
        cq.push_back(16'h0);
        last_cmd = 16'h0;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        send(16, 32'h1554, 16'h0, 16'hffff, 1'b0, 1'b1);
        repeat (20) @(negedge clk);
        if (fq.size() != 0 || cq.size() != 0 || gq.size() != 0)
            fail("expected results left over");
        complete_run();
    end
endmodule

`default_nettype wire
